/* File: pkg/iss_alu_if.sv */
// Carrier between the sequencer and its ALU.
`timescale 1ns/1ps
interface iss_alu_if;
   import iss_pkg::*;
   iss_alu_func_type func; // Operation
   logic [7:0] a; // Accumulator operand
   logic [7:0] b; // Second operand
   logic [3:0] flags_in; // Current status
   logic [7:0] res; // Result
   logic [3:0] flags_out; // Updated status
   modport core (output func, a, b, flags_in, input res, flags_out);
   modport alu (input func, a, b, flags_in, output res, flags_out);
endinterface

/* File: pkg/iss_pkg.sv */
// Constants, opcodes, register map and types of the instruction sequencer.
// What this block does
// - Clock from fast or slow internal oscillator
// - Four phases form one instruction cycle
// - PC advances and fetches at first phase
// - Fetch of next overlaps current execution
// - PC-changing instruction flushes, costs one cycle
// - Taken skip discards fetched word, dummy cycle
// - PC increments by one per instruction
// - Jump, call, interrupt, reset load target
// - Twelve-bit PC, low byte software visible
// - Low byte write jumps within page
// - Low byte write inserts one dummy cycle
// - Six-level PC stack, not software visible
// - Call or interrupt acknowledge pushes PC
// - Return pops stack into PC
// - Reset points stack pointer at top
// - Full stack withholds interrupt acknowledge
// - Call on full stack loses oldest
// - Eight-bit ALU, data through accumulator
// - Result to accumulator, status updated except by step ops
// - Add, subtract, adjust, logic, rotate, step
package iss_pkg;
   // Widths
   localparam int PC_W = 12;
   localparam int IW_W = 16;
   localparam int STK_DEPTH = 6;
   // Register offsets on the plain register port
   localparam logic [7:0] REG_PC_LOW = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h01;
   localparam logic [7:0] REG_ACC = 8'h02;
   localparam logic [7:0] REG_CTRL = 8'h03;
   // Control register fields and reset value
   localparam int CTRL_RUN = 0;
   localparam int CTRL_FAST = 1;
   localparam logic [7:0] CTRL_RST = 8'h03;
   // Status flag positions
   localparam int FLG_C = 0;
   localparam int FLG_AC = 1;
   localparam int FLG_Z = 2;
   localparam int FLG_OV = 3;
   localparam logic [3:0] FLG_RST = 4'h0;
   // Reset and interrupt vectors
   localparam logic [11:0] RESET_VEC = 12'h000;
   localparam logic [11:0] INT_VEC = 12'h004;
   // Instruction classes in word bits 15:12
   localparam logic [3:0] OP_NOP = 4'h0;
   localparam logic [3:0] OP_ALU = 4'h1;
   localparam logic [3:0] OP_JMP = 4'h2;
   localparam logic [3:0] OP_CALL = 4'h3;
   localparam logic [3:0] OP_RET = 4'h4;
   localparam logic [3:0] OP_RET_INT = 4'h5;
   localparam logic [3:0] OP_SZA = 4'h6;
   localparam logic [3:0] OP_SNZA = 4'h7;
   localparam logic [3:0] OP_SIZA = 4'h8;
   localparam logic [3:0] OP_SDZA = 4'h9;
   localparam logic [3:0] OP_PCLA = 4'ha;
   // ALU functions in word bits 11:8
   typedef enum logic [3:0] {
      ALU_ADD = 4'b0000, ALU_ADC = 4'b0001, ALU_SUB = 4'b0010, ALU_SBC = 4'b0011,
      ALU_BCD_ADJ = 4'b0100, ALU_AND = 4'b0101, ALU_OR = 4'b0110, ALU_XOR = 4'b0111,
      ALU_CPL = 4'b1000, ALU_RR = 4'b1001, ALU_RRC = 4'b1010, ALU_RL = 4'b1011,
      ALU_RLC = 4'b1100, ALU_INC = 4'b1101, ALU_DEC = 4'b1110, ALU_MOV = 4'b1111
   } iss_alu_func_type;
   // Instruction cycle phases
   typedef enum logic [1:0] {
      PH_T1 = 2'b00, PH_T2 = 2'b01, PH_T3 = 2'b10, PH_T4 = 2'b11
   } iss_phase_type;
endpackage

/* File: verif/iss_pmem_model.sv */
// Program memory and interrupt requester facing the sequencer.
`timescale 1ns/1ps
module iss_pmem_model
(
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // Fetch side
   input wire logic [11:0] pmem_addr_i,
   output logic [15:0] pmem_data_o,
   // Interrupt side
   input wire logic raise_i,
   input wire logic int_ack_i,
   output logic int_req_o
);
   logic [15:0] mem [0:4095]; // Word store, filled by the bench
   logic req_q; // Pending request

   ////////////////////////////////////////////////////////////////////////
   // Word follows the address at once, so it is settled long before the boundary
   assign pmem_data_o = mem[pmem_addr_i];
   assign int_req_o = req_q;

   // Request stays up until acknowledged; a withheld one is never dropped
   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
         req_q <= 1'b0;
      else if (raise_i)
         req_q <= 1'b1;
      else if (int_ack_i)
         req_q <= 1'b0;
   end
endmodule

/* File: verif/testbench.sv */
// Self-checking bench for the instruction sequencer core.
`timescale 1ns/1ps
module testbench;
   import iss_pkg::*;
   // Design and model wiring
   logic sys_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [11:0] pmem_addr_o;
   logic [15:0] pmem_data_i;
   logic int_req_i;
   logic int_ack_o;
   logic int_raise = 1'b0;
   logic [7:0] reg_addr_i = 8'h00;
   logic [7:0] reg_wdata_i = 8'h00;
   logic reg_wr_i = 1'b0;
   logic reg_rd_i = 1'b0;
   logic [7:0] reg_rdata_o;
   logic [1:0] phase_o;
   logic fast_o;
   logic slow_o;
   logic [1:0] ph_hold; // Phase seen just after freezing
   // Bookkeeping
   int err_total = 0;
   int samples_checked = 0;
   int ack_cnt = 0;
   logic [11:0] trace [$]; // Fetch address of each instruction cycle
   // Accumulator after 96 op 35 with carry clear, by function code
   logic [7:0] alu_exp [16] = '{8'hcb, 8'hcb, 8'h61, 8'h60, 8'h96, 8'h14, 8'hb7, 8'ha3,
                                8'h69, 8'h4b, 8'h4b, 8'h2d, 8'h2c, 8'h97, 8'h95, 8'h35};
   // Skip, call, return and far jump, one entry per instruction cycle
   logic [11:0] trace_exp [15] = '{12'h000, 12'h001, 12'h002, 12'h003, 12'h004, 12'h005,
                                   12'h010, 12'h011, 12'h012, 12'h005, 12'h006, 12'h007,
                                   12'h106, 12'h107, 12'h108};

   ////////////////////////////////////////////////////////////////////////
   // 25 MHz clock
   always #20 sys_clk_i = ~sys_clk_i;

   iss_core DUT (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .pmem_addr_o(pmem_addr_o),
      .pmem_data_i(pmem_data_i), .int_req_i(int_req_i), .int_ack_o(int_ack_o),
      .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
      .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .phase_o(phase_o),
      .fast_internal_oscillator_o(fast_o), .slow_internal_oscillator_o(slow_o));

   iss_pmem_model pmem (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .pmem_addr_i(pmem_addr_o),
      .pmem_data_o(pmem_data_i), .raise_i(int_raise), .int_ack_i(int_ack_o),
      .int_req_o(int_req_i));

   // First-phase fetch addresses, sampled mid-cycle where they are settled
   always @(negedge sys_clk_i)
      if (!rst_i && phase_o === 2'h0)
         trace.push_back(pmem_addr_o);

   // Acknowledge pulses
   always @(posedge sys_clk_i)
      if (int_ack_o === 1'b1)
         ack_cnt++;

   ////////////////////////////////////////////////////////////////////////
   // Compare and count
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         err_total++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One-cycle write strobe
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge sys_clk_i);
      reg_wr_i <= 1'b0;
   endtask

   // One-cycle read strobe; data looked at only in the following cycle
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge sys_clk_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge sys_clk_i);
      reg_rd_i <= 1'b0;
      @(negedge sys_clk_i);
      chk({8'h00, reg_rdata_o}, {8'h00, exp});
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge sys_clk_i);
   endtask

   // Short reset that restarts the program at the reset vector
   task automatic restart();
      @(posedge sys_clk_i);
      rst_i <= 1'b1;
      @(posedge sys_clk_i);
      rst_i <= 1'b0;
      trace.delete();
      ack_cnt = 0;
   endtask

   task automatic wipe();
      for (int i = 0; i < 4096; i++)
         pmem.mem[i] = 16'h0000;
   endtask

   // Five nested calls, a sixth given by last, and a ladder of increment-and-return
   task automatic chain(input logic [15:0] last);
      wipe();
      for (int i = 0; i < 5; i++)
         pmem.mem[i * 16] = 16'h3010 + 16'(i * 16);
      for (int i = 1; i < 7; i++)
      begin
         pmem.mem[i * 16 + 1] = 16'h1d00;
         pmem.mem[i * 16 + 2] = 16'h4000;
      end
      pmem.mem[12'h012] = 16'h2012;
      pmem.mem[12'h050] = last;
      pmem.mem[12'h070] = 16'h4000;
   endtask

   // Verdict and end of run
   task automatic summarize();
      if (err_total == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // Watchdog well beyond the fewer than two thousand cycles the tests need
   initial
   begin
      repeat (20000) @(posedge sys_clk_i);
      err_total++;
      summarize();
   end

   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      wipe();
      repeat (16) @(posedge sys_clk_i);
      chk({4'h0, pmem_addr_o}, {4'h0, RESET_VEC});
      chk({12'h000, phase_o, fast_o, slow_o}, 16'h0002);
      rst_i <= 1'b0;
      // Reset values, read-only places and an unmapped address
      rd(REG_CTRL, CTRL_RST);
      rd(REG_STATUS, 8'h00);
      wr(REG_STATUS, 8'hff);
      wr(REG_ACC, 8'hff);
      wr(8'h7e, 8'hff);
      rd(REG_STATUS, 8'h00);
      rd(REG_ACC, 8'h00);
      rd(8'h7e, 8'h00);
      // Slow oscillator selected, then phases frozen and resumed
      wr(REG_CTRL, 8'h01);
      rd(REG_CTRL, 8'h01);
      chk({14'h0000, fast_o, slow_o}, 16'h0001);
      wr(REG_CTRL, 8'h00);
      @(negedge sys_clk_i);
      ph_hold = phase_o;
      idle(8);
      chk({14'h0000, phase_o}, {14'h0000, ph_hold});
      wr(REG_CTRL, CTRL_RST);
      // Every ALU function once
      for (int f = 0; f < 16; f++)
      begin
         wipe();
         pmem.mem[0] = 16'h1f96;
         pmem.mem[1] = {OP_ALU, f[3:0], 8'h35};
         pmem.mem[2] = 16'h2002;
         restart();
         idle(40);
         rd(REG_ACC, alu_exp[f]);
      end
      // Step-and-skip, skip-if-nonzero and accumulator jump; a wrong path ends in the trap at 0f0
      wipe();
      pmem.mem[12'h000] = 16'h1f02;
      pmem.mem[12'h001] = 16'h9000;
      pmem.mem[12'h002] = 16'h9000;
      pmem.mem[12'h003] = 16'h20f0;
      pmem.mem[12'h004] = 16'h7000;
      pmem.mem[12'h005] = 16'h8000;
      pmem.mem[12'h006] = 16'h7000;
      pmem.mem[12'h007] = 16'h20f0;
      pmem.mem[12'h008] = 16'h1fff;
      pmem.mem[12'h009] = 16'h8000;
      pmem.mem[12'h00a] = 16'h20f0;
      pmem.mem[12'h00b] = 16'h1f30;
      pmem.mem[12'h00c] = 16'ha000;
      pmem.mem[12'h00d] = 16'h20f0;
      pmem.mem[12'h030] = 16'h1d00;
      pmem.mem[12'h031] = 16'h2031;
      pmem.mem[12'h0f0] = 16'h1f40;
      pmem.mem[12'h0f1] = 16'h20f1;
      restart();
      idle(100);
      rd(REG_ACC, 8'h31);
      // Skip, call, return, far jump, then a low-byte jump within page 1
      wipe();
      pmem.mem[12'h000] = 16'h1f05;
      pmem.mem[12'h001] = 16'h10fb;
      pmem.mem[12'h002] = 16'h6000;
      pmem.mem[12'h003] = 16'h1f77;
      pmem.mem[12'h004] = 16'h3010;
      pmem.mem[12'h005] = 16'h107f;
      pmem.mem[12'h006] = 16'h2106;
      pmem.mem[12'h010] = 16'h1d00;
      pmem.mem[12'h011] = 16'h4000;
      pmem.mem[12'h107] = 16'h2106;
      pmem.mem[12'h020] = 16'h1f99;
      pmem.mem[12'h120] = 16'h1f33;
      pmem.mem[12'h121] = 16'h2121;
      restart();
      idle(64);
      foreach (trace_exp[i])
         chk({4'h0, trace[i]}, {4'h0, trace_exp[i]});
      rd(REG_ACC, 8'h80);
      rd(REG_STATUS, 8'h0a);
      wr(REG_PC_LOW, 8'h20);
      idle(24);
      rd(REG_ACC, 8'h33);
      chk({12'h000, pmem_addr_o[11:8]}, 16'h0001);
      // Full stack withholds the acknowledge until a return frees a level
      chain(16'h3080);
      pmem.mem[12'h081] = 16'h2080;
      pmem.mem[12'h090] = 16'h4000;
      pmem.mem[12'h004] = 16'h5000;
      restart();
      idle(120);
      int_raise <= 1'b1;
      @(posedge sys_clk_i);
      int_raise <= 1'b0;
      idle(60);
      chk(16'(ack_cnt), 16'h0000);
      wr(REG_PC_LOW, 8'h90);
      idle(200);
      chk(16'(ack_cnt), 16'h0001);
      rd(REG_ACC, 8'h05);
      // Seventh call overwrites the oldest return address
      chain(16'h3060);
      pmem.mem[12'h060] = 16'h3070;
      restart();
      idle(240);
      rd(REG_ACC, 8'h06);
      chk({4'h0, pmem_addr_o & 12'hffe}, 16'h0012);
      summarize();
   end
endmodule

/* File: verilog/iss_alu.sv */
// Eight-bit combinational ALU with status generation.
`timescale 1ns/1ps
module iss_alu
   import iss_pkg::*;
(
   // Operands and results
   iss_alu_if.alu bus
);
   logic sub_op; // Subtract class
   logic carry_op; // Uses carry in
   logic [7:0] bx; // Second operand, inverted for subtract
   logic ci; // Carry into bit 0
   logic [8:0] sum; // Adder with carry out
   logic [4:0] nib; // Low nibble adder for half carry

   ////////////////////////////////////////////////////////////////////////
   // Shared adder; subtract carry means no borrow
   assign sub_op = (bus.func == ALU_SUB) || (bus.func == ALU_SBC);
   assign carry_op = (bus.func == ALU_ADC) || (bus.func == ALU_SBC);
   assign bx = sub_op ? ~bus.b : bus.b;
   assign ci = carry_op ? bus.flags_in[FLG_C] : sub_op;
   assign sum = {1'b0, bus.a} + {1'b0, bx} + {8'h00, ci};
   assign nib = {1'b0, bus.a[3:0]} + {1'b0, bx[3:0]} + {4'h0, ci};

   ////////////////////////////////////////////////////////////////////////
   // Function select and flag update
   always_comb
   begin
      logic [8:0] d;
      logic [7:0] r;
      logic [3:0] f;
      d = {1'b0, bus.a};
      r = bus.a;
      f = bus.flags_in;
      case (bus.func)
         // Add and subtract, with and without carry
         ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC:
         begin
            r = sum[7:0];
            f[FLG_C] = sum[8];
            f[FLG_AC] = nib[4];
            f[FLG_OV] = (bus.a[7] == bx[7]) && (r[7] != bus.a[7]);
         end
         // Decimal adjust after a packed BCD add
         ALU_BCD_ADJ:
         begin
            if ((bus.a[3:0] > 4'h9) || bus.flags_in[FLG_AC])
            begin
               d = d + 9'h006;
            end
            if ((d[7:4] > 4'h9) || bus.flags_in[FLG_C] || d[8])
            begin
               d = d + 9'h060;
            end
            r = d[7:0];
            f[FLG_C] = d[8] | bus.flags_in[FLG_C];
         end
         ALU_AND: r = bus.a & bus.b;
         ALU_OR: r = bus.a | bus.b;
         ALU_XOR: r = bus.a ^ bus.b;
         ALU_CPL: r = ~bus.a;
         // Rotations; the carry forms a ninth bit in RRC and RLC
         ALU_RR: r = {bus.a[0], bus.a[7:1]};
         ALU_RL: r = {bus.a[6:0], bus.a[7]};
         ALU_RRC:
         begin
            r = {bus.flags_in[FLG_C], bus.a[7:1]};
            f[FLG_C] = bus.a[0];
         end
         ALU_RLC:
         begin
            r = {bus.a[6:0], bus.flags_in[FLG_C]};
            f[FLG_C] = bus.a[7];
         end
         ALU_INC: r = bus.a + 8'h01;
         ALU_DEC: r = bus.a - 8'h01;
         ALU_MOV: r = bus.b;
         default: r = bus.a;
      endcase
      // Zero follows every result; rotations keep it too, for simplicity
      f[FLG_Z] = (r == 8'h00);
      bus.res = r;
      bus.flags_out = f;
   end
endmodule

/* File: verilog/iss_core.sv */
// Instruction sequencer: phases, pipeline, program counter, stack and register port.
`timescale 1ns/1ps
module iss_core
   import iss_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // Program memory
   output logic [11:0] pmem_addr_o,
   input wire logic [15:0] pmem_data_i,
   // Interrupt request logic
   input wire logic int_req_i,
   output logic int_ack_o,
   // Register port
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   // Status
   output logic [1:0] phase_o,
   output logic fast_internal_oscillator_o,
   output logic slow_internal_oscillator_o
);
   ////////////////////////////////////////////////////////////////////////
   // Declarations
   iss_phase_type phase_q; // Current phase
   iss_phase_type phase_d;
   logic [11:0] pc_q; // Address being fetched
   logic [11:0] pc_d;
   logic [15:0] ir_q; // Word under execution
   logic ir_valid_q; // Low in a dummy cycle
   logic [7:0] acc_q; // Accumulator
   logic [3:0] flags_q; // Status register
   logic [7:0] ctrl_q; // Run and oscillator select
   logic lowb_pend_q; // Software low byte write waiting
   logic [7:0] lowb_val_q; // Value of that write
   logic [11:0] stk_mem_q [0:STK_DEPTH-1]; // Return addresses
   logic [2:0] stk_wp_q; // Next free slot
   logic [2:0] stk_cnt_q; // Levels in use
   logic [7:0] rdata_q; // Read data
   logic int_ack_q; // Acknowledge pulse
   logic [1:0] phase_out_q; // Phase seen outside
   logic fast_q; // Fast oscillator select
   logic slow_q; // Slow oscillator select

   // Decode wires
   logic run; // Sequencer enabled
   logic boundary; // Last phase of an instruction cycle
   logic [3:0] op; // Instruction class
   logic exec; // A real instruction is executing
   logic is_jmp, is_call, is_ret, is_pcla, is_alu, is_step;
   logic instr_redir; // Instruction changes the PC
   logic skip_take; // Taken conditional skip
   logic lowb_take; // Software low byte write applied now
   logic stk_full; // All six levels used
   logic int_take; // Interrupt acknowledged now
   logic redirect; // Fetched word must be flushed
   logic [11:0] target; // New PC on redirect
   logic [11:0] stk_top; // Most recent saved PC
   logic push, pop;
   logic [7:0] rd_mux; // Read selection

   iss_alu_if alu_if ();

   // Wrap a stack index one slot back
   function automatic logic [2:0] stk_prev(input logic [2:0] i);
      stk_prev = (i == 3'd0) ? 3'(STK_DEPTH - 1) : i - 3'd1;
   endfunction

   // Wrap a stack index one slot forward
   function automatic logic [2:0] stk_next(input logic [2:0] i);
      stk_next = (i == 3'(STK_DEPTH - 1)) ? 3'd0 : i + 3'd1;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Phase generator; a cleared run bit freezes the sequence in place
   assign run = ctrl_q[CTRL_RUN];
   assign boundary = run && (phase_q == PH_T4);

   always_comb
   begin
      phase_d = phase_q;
      if (run)
      begin
         case (phase_q)
            PH_T1: phase_d = PH_T2;
            PH_T2: phase_d = PH_T3;
            PH_T3: phase_d = PH_T4;
            PH_T4: phase_d = PH_T1;
            default: phase_d = PH_T1;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Instruction decode
   assign op = ir_q[15:12];
   assign exec = ir_valid_q;
   assign is_jmp = exec && (op == OP_JMP);
   assign is_call = exec && (op == OP_CALL);
   assign is_ret = exec && ((op == OP_RET) || (op == OP_RET_INT));
   assign is_pcla = exec && (op == OP_PCLA);
   assign is_alu = exec && (op == OP_ALU);
   assign is_step = exec && ((op == OP_SIZA) || (op == OP_SDZA));
   assign instr_redir = is_jmp || is_call || is_ret || is_pcla;

   // ALU operands: class ALU takes an immediate, step ops use inc or dec
   assign alu_if.func = is_alu ? iss_alu_func_type'(ir_q[11:8]) : ((op == OP_SDZA) ? ALU_DEC : ALU_INC);
   assign alu_if.a = acc_q;
   assign alu_if.b = ir_q[7:0];
   assign alu_if.flags_in = flags_q;

   iss_alu u_alu (
      .bus (alu_if)
   );

   // Skip decisions look at the accumulator or the stepped value
   assign skip_take = exec && (((op == OP_SZA) && (acc_q == 8'h00))
                               || ((op == OP_SNZA) && (acc_q != 8'h00))
                               || (is_step && (alu_if.res == 8'h00)));

   ////////////////////////////////////////////////////////////////////////
   // Redirect arbitration: instruction first, then software write, then
   // interrupt. Interrupts wait out dummy cycles so the return address is
   // always the flushed word's own address.
   assign stk_full = (stk_cnt_q == 3'(STK_DEPTH));
   // A taken skip defers the write to the dummy cycle, so the skip keeps its own PC step
   assign lowb_take = lowb_pend_q && !instr_redir && !skip_take;
   assign int_take = int_req_i && exec && !instr_redir && !skip_take && !lowb_pend_q && !stk_full;
   assign redirect = instr_redir || lowb_take || int_take;
   assign stk_top = stk_mem_q[stk_prev(stk_wp_q)];
   assign push = boundary && (is_call || int_take);
   assign pop = boundary && is_ret;

   always_comb
   begin
      target = pc_q + 12'h001;
      if (is_jmp || is_call)
      begin
         target = ir_q[11:0];
      end
      else if (is_ret)
      begin
         target = stk_top;
      end
      else if (is_pcla)
      begin
         target = {pc_q[11:8], acc_q};
      end
      else if (lowb_take)
      begin
         target = {pc_q[11:8], lowb_val_q};
      end
      else if (int_take)
      begin
         target = INT_VEC;
      end
   end

   // Next fetch address at the start of the coming first phase
   assign pc_d = redirect ? target : pc_q + 12'h001;

   ////////////////////////////////////////////////////////////////////////
   // Phase and pipeline registers
   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         phase_q <= PH_T1;
         pc_q <= RESET_VEC;
         ir_q <= 16'h0000;
         ir_valid_q <= 1'b0;
      end
      else
      begin
         phase_q <= phase_d;
         if (boundary)
         begin
            pc_q <= pc_d;
            ir_q <= pmem_data_i;
            ir_valid_q <= !(redirect || skip_take);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Accumulator and status; only the execute boundary writes them
   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         acc_q <= 8'h00;
         flags_q <= FLG_RST;
      end
      else if (boundary && (is_alu || is_step))
      begin
         acc_q <= alu_if.res;
         if (is_alu)
         begin
            flags_q <= alu_if.flags_out;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Return stack, circular: a push when full overwrites the oldest slot
   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         stk_wp_q <= 3'd0;
         stk_cnt_q <= 3'd0;
      end
      else if (push)
      begin
         stk_wp_q <= stk_next(stk_wp_q);
         if (!stk_full)
         begin
            stk_cnt_q <= stk_cnt_q + 3'd1;
         end
      end
      else if (pop)
      begin
         stk_wp_q <= stk_prev(stk_wp_q);
         if (stk_cnt_q != 3'd0)
         begin
            stk_cnt_q <= stk_cnt_q - 3'd1;
         end
      end
   end

   // Stack storage has no reset; contents are undefined until pushed
   always_ff @(posedge sys_clk_i)
   begin
      if (push)
      begin
         stk_mem_q[stk_wp_q] <= pc_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Register port; the stack has no address, unmapped reads give zero
   always_comb
   begin
      case (reg_addr_i)
         REG_PC_LOW: rd_mux = pc_q[7:0];
         REG_STATUS: rd_mux = {4'h0, flags_q};
         REG_ACC: rd_mux = acc_q;
         REG_CTRL: rd_mux = ctrl_q;
         default: rd_mux = 8'h00;
      endcase
   end

   // Software writes; a low byte write waits for a boundary with no PC-changing
   // instruction or taken skip, and a new write in that same cycle keeps the request alive
   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         ctrl_q <= CTRL_RST;
         lowb_pend_q <= 1'b0;
         lowb_val_q <= 8'h00;
         rdata_q <= 8'h00;
      end
      else
      begin
         rdata_q <= reg_rd_i ? rd_mux : 8'h00;
         if (reg_wr_i && (reg_addr_i == REG_CTRL))
         begin
            ctrl_q <= reg_wdata_i;
         end
         if (reg_wr_i && (reg_addr_i == REG_PC_LOW))
         begin
            lowb_pend_q <= 1'b1;
            lowb_val_q <= reg_wdata_i;
         end
         else if (boundary && lowb_take)
         begin
            lowb_pend_q <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Output flops
   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         int_ack_q <= 1'b0;
         phase_out_q <= PH_T1;
         fast_q <= 1'b1;
         slow_q <= 1'b0;
      end
      else
      begin
         int_ack_q <= boundary && int_take;
         phase_out_q <= phase_d;
         fast_q <= ctrl_q[CTRL_FAST];
         slow_q <= !ctrl_q[CTRL_FAST];
      end
   end

   assign pmem_addr_o = pc_q;
   assign int_ack_o = int_ack_q;
   assign reg_rdata_o = rdata_q;
   assign phase_o = phase_out_q;
   assign fast_internal_oscillator_o = fast_q;
   assign slow_internal_oscillator_o = slow_q;

   ////////////////////////////////////////////////////////////////////////
   // Assertions
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (rst_i);

   cycle_len_a: assert property (boundary && run |=> !boundary [*3])
      else $error("instruction cycle shorter than four phases");
   pc_step_a: assert property (boundary && !redirect |=> pc_q == $past(pc_q) + 12'h001)
      else $error("pc did not step by one");
   flush_a: assert property (boundary && instr_redir |=> !ir_valid_q)
      else $error("fetched word not flushed on redirect");
   skip_a: assert property (boundary && skip_take |=> !ir_valid_q && pc_q == $past(pc_q) + 12'h001)
      else $error("skip did not insert a dummy cycle");
   push_a: assert property (push && !stk_full |=> stk_cnt_q == $past(stk_cnt_q) + 3'd1 && stk_top == $past(pc_q))
      else $error("push did not save the pc");
   ret_a: assert property (pop |=> pc_q == $past(stk_top))
      else $error("return did not restore the pc");
   ack_full_a: assert property (int_ack_o |-> $past(!stk_full && int_req_i))
      else $error("acknowledge given with stack full");
   page_a: assert property (boundary && (lowb_take || is_pcla) |=> pc_q[11:8] == $past(pc_q[11:8]) && !ir_valid_q)
      else $error("low byte write left its page");
   overflow_a: assert property (push && stk_full |=> stk_cnt_q == 3'(STK_DEPTH))
      else $error("overflow changed the level count");

   call_c: cover property (boundary && is_call);
   ret_c: cover property (pop && stk_cnt_q == 3'd1);
   int_c: cover property (int_ack_o);
   skip_c: cover property (boundary && skip_take);
   full_c: cover property (push && stk_full);
endmodule
